//--- rtl/tpbm_defines.svh
`ifndef TPBM_DEFINES_SVH
`define TPBM_DEFINES_SVH

// Geometry of the bank memory
`define TPBM_NUM_BANKS    6
`define TPBM_BANK_WORDS   1024
`define TPBM_WORD_BITS    16
`define TPBM_SEL_BITS     10
`define TPBM_BANK_BITS    3
`define TPBM_ADDR_BITS    13
// Bank field position inside a word address
`define TPBM_BANK_LSB     10
`define TPBM_BANK_MSB     12
// Wait-states added on a same-bank collision
`define TPBM_COLLIDE_WAIT 1
// Read data output value when no answer is pending, and reset value of the held write data
`define TPBM_DATA_RST     16'h0000

`endif

//--- rtl/tpbm_pkg.sv
package tpbm_pkg;
    // Arbiter phase: normal, or serving the held instruction access
    typedef enum logic {
        TPBM_IDLE,
        TPBM_SECOND
    } tpbm_state_type;

    typedef logic [15:0] tpbm_word_type;
endpackage

//--- rtl/tpbm_bank.sv
`timescale 1ns/100ps
`include "tpbm_defines.svh"

// One 1K x 16 bank with two independent ports, registered read data
module tpbm_bank (
    // Clock
    input  wire logic        i_ref_clk,
    input  wire logic        i_ce,
    // Port A
    input  wire logic        i_a_en,
    input  wire logic        i_a_we,
    input  wire logic [9:0]  i_a_addr,
    input  wire logic [15:0] i_a_wdata,
    output logic      [15:0] o_a_rdata,
    // Port B
    input  wire logic        i_b_en,
    input  wire logic        i_b_we,
    input  wire logic [9:0]  i_b_addr,
    input  wire logic [15:0] i_b_wdata,
    output logic      [15:0] o_b_rdata
);
    logic [15:0] mem [0:`TPBM_BANK_WORDS-1];

    // Both ports in one process so the array has a single driver; the arbiter
    // never enables both ports of one bank in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_ce && i_a_en) begin
            if (i_a_we)
                mem[i_a_addr] <= i_a_wdata;
            o_a_rdata <= mem[i_a_addr];
        end
        if (i_ce && i_b_en) begin
            if (i_b_we)
                mem[i_b_addr] <= i_b_wdata;
            o_b_rdata <= mem[i_b_addr];
        end
    end
endmodule

//--- rtl/tpbm_two_port_bank_memory.sv
`timescale 1ns/100ps
`include "tpbm_defines.svh"

// What this block does
// RULE_01: Six independent banks, each 1K words of 16 bits.
// RULE_02: A non-colliding access completes with no wait-state.
// RULE_03: Each bank has an instruction-side port and a data-side port.
// RULE_04: Every location is reachable from both spaces.
// RULE_05: Bank steering is done in hardware, never by software.
// RULE_06: Same-bank collision stalls the requester for one wait-state.
// RULE_07: On collision, data access goes first, instruction access next cycle.
// RULE_08: Bank index is the bits above the ten word-select bits, compared each cycle.
module tpbm_two_port_bank_memory (
    // Clock, enable and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_ce,
    input  wire logic        i_resetn,
    // Instruction/coefficient space request
    input  wire logic        i_x_req,
    input  wire logic        i_x_we,
    input  wire logic [12:0] i_x_addr,
    input  wire logic [15:0] i_x_wdata,
    // Data space request
    input  wire logic        i_y_req,
    input  wire logic        i_y_we,
    input  wire logic [12:0] i_y_addr,
    input  wire logic [15:0] i_y_wdata,
    // Answers
    output logic      [15:0] o_x_rdata,
    output logic      [15:0] o_y_rdata,
    output logic             o_x_valid,
    output logic             o_y_valid,
    output logic             o_stall
);
    // Bank count as an int for loops and range tests
    localparam int NB = `TPBM_NUM_BANKS;

    // Arbiter phase register
    tpbm_pkg::tpbm_state_type state;
    tpbm_pkg::tpbm_state_type next_state;

    // Held instruction request while the data access takes the bank
    // Only the instruction side can lose, so only it needs a copy
    logic        x_held_we;
    logic [12:0] x_held_addr;
    logic [15:0] x_held_wdata;
    logic        x_pend;
    logic        y_pend;
    logic [2:0]  x_bank_q;
    logic [2:0]  y_bank_q;

    // Bank field of a word address
    function automatic logic [2:0] bank_of(input logic [12:0] addr);
        bank_of = addr[`TPBM_BANK_MSB:`TPBM_BANK_LSB]; // [RULE_08]
    endfunction

    // Legal address decode: only banks 0..5 exist
    function automatic logic in_range(input logic [12:0] addr);
        in_range = (bank_of(addr) < 3'(NB));
    endfunction

    // Phase decode
    wire        second    = (state == tpbm_pkg::TPBM_SECOND);
    // Instruction side is either new request or the held one
    wire        x_act     = second ? 1'b1 : (i_x_req && in_range(i_x_addr));
    wire        x_we      = second ? x_held_we : i_x_we;
    wire [12:0] x_addr    = second ? x_held_addr : i_x_addr;
    wire [15:0] x_wdata   = second ? x_held_wdata : i_x_wdata;
    // Data side is never held: it always wins a collision
    wire        y_act     = !second && i_y_req && in_range(i_y_addr);
    wire [2:0]  x_bank    = bank_of(x_addr);
    wire [2:0]  y_bank    = bank_of(i_y_addr);
    // Same-bank test every cycle, both ports compared
    wire        collide   = x_act && y_act && (x_bank == y_bank); // [RULE_08] [RULE_06]
    wire        x_go      = x_act && !collide; // [RULE_07]

    // Stall covers the wait-state cycle and the colliding cycle
    // Combinational so the core sees the stall in the colliding cycle itself
    assign o_stall = collide || second; // [RULE_06]

    // Arbiter phase
    // Only one wait-state exists, so two phases suffice
    always_comb begin
        case (state)
            tpbm_pkg::TPBM_IDLE:   next_state = collide ? tpbm_pkg::TPBM_SECOND
                                                        : tpbm_pkg::TPBM_IDLE;
            tpbm_pkg::TPBM_SECOND: next_state = tpbm_pkg::TPBM_IDLE;
            default:               next_state = tpbm_pkg::TPBM_IDLE;
        endcase
    end

    // Phase flop; i_ce low holds it
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= tpbm_pkg::TPBM_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // Capture the losing instruction request
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            x_held_we    <= 1'b0;
            x_held_addr  <= 13'h0000;
            x_held_wdata <= `TPBM_DATA_RST;
        end else if (i_ce && collide) begin
            x_held_we    <= i_x_we;
            x_held_addr  <= i_x_addr;
            x_held_wdata <= i_x_wdata;
        end
    end

    // Remember which bank answers next cycle
    // The bank number is kept so the read mux picks the bank that really answered
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            x_pend   <= 1'b0;
            y_pend   <= 1'b0;
            x_bank_q <= 3'h0;
            y_bank_q <= 3'h0;
        end else if (i_ce) begin
            x_pend   <= x_go; // [RULE_02]
            y_pend   <= y_act; // [RULE_02] [RULE_07]
            x_bank_q <= x_bank;
            y_bank_q <= y_bank;
        end
    end

    // Per-bank steering, done entirely in hardware
    logic [15:0] x_rd [0:NB-1];
    logic [15:0] y_rd [0:NB-1];

    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            // A port is enabled only for the bank its address selects
            wire x_hit = x_go && (x_bank == 3'(b)); // [RULE_05] [RULE_04]
            wire y_hit = y_act && (y_bank == 3'(b)); // [RULE_05] [RULE_04]
            // Two ports per bank: instruction side on A, data side on B
            tpbm_bank u_bank ( // [RULE_01] [RULE_03]
                .i_ref_clk (i_ref_clk),
                .i_ce      (i_ce),
                .i_a_en    (x_hit),
                .i_a_we    (x_we),
                .i_a_addr  (x_addr[9:0]),
                .i_a_wdata (x_wdata),
                .o_a_rdata (x_rd[b]),
                .i_b_en    (y_hit),
                .i_b_we    (i_y_we),
                .i_b_addr  (i_y_addr[9:0]),
                .i_b_wdata (i_y_wdata),
                .o_b_rdata (y_rd[b])
            );
        end
    endgenerate

    // Read data straight from the bank output registers; a bank keeps its
    // last read, so the pend flags gate stale words to zero
    // Clamp keeps the array index legal even for an unmapped bank field
    wire [2:0] xsel = (x_bank_q < 3'(NB)) ? x_bank_q : 3'h0;
    wire [2:0] ysel = (y_bank_q < 3'(NB)) ? y_bank_q : 3'h0;
    assign o_x_rdata = x_pend ? x_rd[xsel] : `TPBM_DATA_RST;
    assign o_y_rdata = y_pend ? y_rd[ysel] : `TPBM_DATA_RST;
    assign o_x_valid = x_pend;
    assign o_y_valid = y_pend;

    // Checks: a collision costs exactly one wait-state
    AST_STALL_ON_COLLIDE: assert property ( // [RULE_06]
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && collide) |=> (o_stall && second))
        else $error("Collision did not insert a wait-state");
    AST_ONE_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_06]
        (i_ce && second) |=> !second)
        else $error("Wait-state lasted more than one cycle");

    // Data side wins the bank; the losing instruction access is replayed unchanged
    AST_DATA_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_07]
        (i_ce && collide) |=> (y_pend && !x_pend))
        else $error("Data access not served first");
    AST_INSTR_NEXT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_07]
        (i_ce && collide) ##1 i_ce |=> x_pend)
        else $error("Instruction access not served after wait");
    AST_HOLD_X: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_07]
        (i_ce && collide) |=> (x_addr == $past(i_x_addr) && x_we == $past(i_x_we)
                               && x_wdata == $past(i_x_wdata)))
        else $error("Held instruction access changed during the wait");
    AST_Y_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_07]
        (i_ce && !second && i_y_req && in_range(i_y_addr)) |=> o_y_valid)
        else $error("Data access was made to wait");

    // Without a collision nothing waits, and two banks work side by side
    AST_ZERO_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_02]
        (i_ce && !second && i_x_req && in_range(i_x_addr) && !collide) |=> o_x_valid)
        else $error("Non-colliding access was delayed");
    AST_PARALLEL: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_03]
        (i_ce && x_act && y_act && x_bank != y_bank) |=> (x_pend && y_pend))
        else $error("Two banks not used in one cycle");
    AST_NO_STALL_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_02]
        (!second && !(i_x_req && i_y_req)) |-> !o_stall)
        else $error("Stall without collision");

    // Collision judged from the ports, so a broken compare cannot vouch for itself
    AST_COMPARE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_08]
        (!second && i_x_req && i_y_req && in_range(i_x_addr) && in_range(i_y_addr)
         && i_x_addr[`TPBM_BANK_MSB:`TPBM_BANK_LSB] == i_y_addr[`TPBM_BANK_MSB:`TPBM_BANK_LSB])
        |-> o_stall)
        else $error("Same bank not detected");
    AST_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_08]
        (i_ce && !second && i_x_req && !in_range(i_x_addr)) |=> !o_x_valid)
        else $error("Unmapped bank answered");

    // Clock enable low freezes phase, answers and read data
    // Stale read data must not drift while the core is held off
    AST_FREEZE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE_02]
        !i_ce |=> ($stable(state) && $stable(x_pend) && $stable(y_pend)
                   && $stable(o_x_rdata) && $stable(o_y_rdata)))
        else $error("State moved while clock enable was low");

    // Main scenarios worth seeing at least once
    COV_COLLIDE: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) i_ce && collide);
    COV_PARALLEL: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_ce && x_act && y_act && !collide);
    COV_BACK2BACK: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && collide) ##3 (i_ce && collide));
    COV_FREEZE: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !i_ce && o_x_valid);
    COV_UNMAPPED: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_ce && i_x_req && i_y_req && !in_range(i_x_addr) && !o_stall);
endmodule

//--- verif/tpbm_core_model.sv
`timescale 1ns/100ps

// Behavioural processor core: drives the instruction and data space buses
module tpbm_core_model (
    // Instruction space bus
    output logic        o_x_req,
    output logic        o_x_we,
    output logic [12:0] o_x_addr,
    output logic [15:0] o_x_wdata,
    // Data space bus
    output logic        o_y_req,
    output logic        o_y_we,
    output logic [12:0] o_y_addr,
    output logic [15:0] o_y_wdata
);
    // Released buses drop both requests and show the inverse of the last address and write data, so stale data never looks valid
    task automatic idle();
        o_x_req   = 1'b0;
        o_y_req   = 1'b0;
        o_x_addr  = ~o_x_addr;
        o_y_addr  = ~o_y_addr;
        o_x_wdata = ~o_x_wdata;
        o_y_wdata = ~o_y_wdata;
    endtask

    // Present one request pair; caller holds it until the taking edge
    task automatic drive(input logic xr, input logic xw, input logic [12:0] xa,
                         input logic [15:0] xd, input logic yr, input logic yw,
                         input logic [12:0] ya, input logic [15:0] yd);
        o_x_req   = xr;
        o_x_we    = xw;
        o_x_addr  = xa;
        o_x_wdata = xd;
        o_y_req   = yr;
        o_y_we    = yw;
        o_y_addr  = ya;
        o_y_wdata = yd;
    endtask

    // Quiet buses at time zero
    initial begin
        drive(1'b0, 1'b0, 13'h0000, 16'h0000, 1'b0, 1'b0, 13'h0000, 16'h0000);
    end
endmodule

//--- verif/test_tpbm_two_port_bank_memory.sv
`timescale 1ns/100ps

module test_tpbm_two_port_bank_memory;
    logic        i_ref_clk = 1'b0;
    logic        i_resetn  = 1'b0;
    logic        i_ce      = 1'b1;
    logic        x_req, x_we, y_req, y_we, x_valid, y_valid, stall;
    logic [12:0] x_addr, y_addr;
    logic [15:0] x_wdata, y_wdata, x_rdata, y_rdata;
    int          fails    = 0;
    int          n_checks = 0;
    int          cycles   = 0;

    // 50 MHz clock
    always #10 i_ref_clk = ~i_ref_clk;

    tpbm_core_model i_core (.o_x_req(x_req), .o_x_we(x_we), .o_x_addr(x_addr),
        .o_x_wdata(x_wdata), .o_y_req(y_req), .o_y_we(y_we), .o_y_addr(y_addr),
        .o_y_wdata(y_wdata));

    tpbm_two_port_bank_memory i_dut (.i_ref_clk(i_ref_clk), .i_ce(i_ce),
        .i_resetn(i_resetn), .i_x_req(x_req), .i_x_we(x_we), .i_x_addr(x_addr),
        .i_x_wdata(x_wdata), .i_y_req(y_req), .i_y_we(y_we), .i_y_addr(y_addr),
        .i_y_wdata(y_wdata), .o_x_rdata(x_rdata), .o_y_rdata(y_rdata),
        .o_x_valid(x_valid), .o_y_valid(y_valid), .o_stall(stall));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Inputs move 1 ns after the rising edge
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask

    // Back-to-back writes to two different banks, then cross-space reads
    task automatic s_banks(input logic rd);
        for (int b = 0; b <= 6; b++) begin
            tick();
            if (b > 0) begin
                chk(16'({x_valid, y_valid, stall}), 16'h0006);
                if (rd) begin
                    chk(x_rdata, 16'(16'h1000 + b - 1));
                    chk(y_rdata, 16'(16'h2000 + b - 1));
                end
            end
            if (b < 6) begin
                i_core.drive(1'b1, ~rd, {3'((b + rd) % 6), 10'h000 | {10{rd}}},
                    16'(16'h2000 + b), 1'b1, ~rd, {3'((b + !rd) % 6), 10'h000 | {10{!rd}}},
                    16'(16'h1000 + b));
            end else begin
                i_core.idle();
            end
        end
    endtask

    // Same-bank pair: data side first, instruction side one wait later
    task automatic s_collide(input logic [12:0] xa, input logic [12:0] ya,
                             input logic yw, input logic [15:0] yd, input logic [15:0] ex);
        tick();
        i_core.drive(1'b1, 1'b0, xa, 16'h0000, 1'b1, yw, ya, yd);
        #1;
        chk(16'(stall), 16'h0001);
        tick();
        i_core.idle();
        chk(16'({x_valid, y_valid, stall}), 16'h0003);
        if (!yw) begin
            chk(y_rdata, yd);
        end
        tick();
        chk(16'({x_valid, y_valid, stall}), 16'h0004);
        chk(x_rdata, ex);
    endtask

    // Bank field 6 lies outside the six banks: no answer and no collision
    task automatic s_unmapped();
        tick();
        i_core.drive(1'b1, 1'b0, 13'h1805, 16'h0000, 1'b1, 1'b0, 13'h1805, 16'h0000);
        #1;
        chk(16'(stall), 16'h0000);
        tick();
        i_core.idle();
        chk(16'({x_valid, y_valid, stall}), 16'h0000);
    endtask

    // Clock enable low: nothing is taken, and what stands stays put
    task automatic s_freeze();
        tick();
        i_ce = 1'b0;
        i_core.drive(1'b1, 1'b0, 13'h0000, 16'h0000, 1'b1, 1'b0, 13'h07ff, 16'h0000);
        tick();
        chk(16'({x_valid, y_valid}), 16'h0000);
        i_ce = 1'b1;
        tick();
        i_core.idle();
        i_ce = 1'b0;
        chk(16'({x_valid, y_valid, stall}), 16'h0006);
        chk(x_rdata, 16'h2000);
        chk(y_rdata, 16'h1000);
        tick();
        chk(16'({x_valid, y_valid}), 16'h0003);
        chk(y_rdata, 16'h1000);
        i_ce = 1'b1;
        tick();
        chk(16'({x_valid, y_valid}), 16'h0000);
    endtask

    // Reset in the wait cycle drops the held instruction access
    task automatic s_reset();
        tick();
        i_core.drive(1'b1, 1'b0, 13'h0800, 16'h0000, 1'b1, 1'b0, 13'h0800, 16'h0000);
        tick();
        i_core.idle();
        i_resetn = 1'b0;
        #1;
        chk(16'({x_valid, y_valid, stall}), 16'h0000);
        repeat (2) tick();
        i_resetn = 1'b1;
        tick();
        chk(16'({x_valid, y_valid, stall}), 16'h0000);
        tick();
        i_core.drive(1'b1, 1'b0, 13'h0800, 16'h0000, 1'b0, 1'b0, 13'h0000, 16'h0000);
        tick();
        i_core.idle();
        chk(16'({x_valid, stall}), 16'h0002);
        chk(x_rdata, 16'h2002);
    endtask

    // Cycle ceiling well above the under forty cycles the run needs
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk(16'({x_valid, y_valid}), 16'h0000);
        i_resetn = 1'b1;
        s_banks(1'b0);
        s_banks(1'b1);
        s_collide(13'h0fff, 13'h0c00, 1'b0, 16'h2003, 16'h1002);
        s_collide(13'h1005, 13'h1005, 1'b1, 16'hbeef, 16'hbeef);
        s_unmapped();
        s_freeze();
        s_reset();
        conclude();
    end
endmodule
